// ===== inc/spi_port_pkg.sv
// Package: register map, field positions and types of the serial port
package spi_port_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'hF3; // serial_control_register
	localparam logic [7:0] ADDR_STAT = 8'hF4; // serial_status_register
	localparam logic [7:0] ADDR_DATA = 8'hF5; // shift_data_register
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [7:0] ALL_ONES  = 8'hFF;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_SELECT_OUTPUT_ENABLE = 7;
	localparam int CTRL_EN   = 6;
	localparam int CTRL_LSBF = 5;
	localparam int CTRL_MASTER_SELECT = 4;
	localparam int CTRL_CLOCK_IDLE_LEVEL = 3;
	localparam int CTRL_CLOCK_SAMPLE_PHASE = 2;
	localparam int STAT_DONE = 7;
	localparam int STAT_WRITE_COLLISION_FLAG = 6;
	localparam int STAT_OVF  = 5;
	localparam int STAT_MODE_FAULT_FLAG = 4;
	localparam int STAT_DISM = 3;

	// ------------------------------------------------------------------
	// Timing: half serial clock period in system clocks per rate code
	// ------------------------------------------------------------------
	// Shortest half period covers the two-flop data input path plus one
	localparam logic [7:0] HALF_DIV0 = 8'h04;
	localparam logic [7:0] HALF_DIV1 = 8'h08;
	localparam logic [7:0] HALF_DIV2 = 8'h10;
	localparam logic [7:0] HALF_DIV3 = 8'h20;
	localparam logic [3:0] EDGES_PER_BYTE = 4'h0; // wraps after 16 edges
	localparam logic [3:0] LAST_EDGE = 4'hF;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01
	} xfer_state_e;

	// Pins of the serial link as seen by the block
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
		logic ss_n;
	} link_in_s;

	typedef struct packed {
		logic sclk_o;
		logic sclk_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic ss_n_o;
		logic ss_n_oe;
	} link_out_s;

endpackage : spi_port_pkg

// ===== design/spi_port.sv
// Design: byte-wide serial peripheral port, master or slave
`timescale 1ns/1ps
`default_nettype none

// Function
// [RULE1] Select pin role from mode, detect, output-enable
// [RULE2] Done flag set by hardware, cleared by software
// [RULE3] Data write blocked while done flag set
// [RULE4] Collision flag sticky until software clears
// [RULE5] Overrun flag sticky until software clears
// [RULE6] Master select low sets mode fault
// [RULE7] Fault detect disable matters only as master
// [RULE8] Interrupt when enabled flag set, both enables
// [RULE9] Write loads shifter; read returns receive buffer
// [RULE10] Master write starts clock and byte exchange
// [RULE11] After eight bits: stop, buffer, done flag
// [RULE12] Slave clock and select are inputs
// [RULE13] Slave select high aborts, fills ones
// [RULE14] Idle level and sample phase from control
// [RULE15] Phase 0 slave drives first bit at select
// [RULE16] Phase 0 slave write under select collides
// [RULE17] Phase 1 slave drives first bit on edge
// [RULE18] Config change while enabled aborts transfer
// [RULE19] Partner uses same clock format
// [RULE20] Mode fault clears master and enable
// [RULE21] Phase 0 samples first edge, 1 second
// [RULE22] Clock rests at idle level
// [RULE23] Overrun keeps previous buffered byte
// [RULE24] Master clock divided by rate select
module spi_port
	import spi_port_pkg::*;
(
	// System
	input  wire logic      clk_sys,
	input  wire logic      nrst,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// Interrupt enables and request
	input  wire logic       serial_irq_enable,
	input  wire logic       global_irq_enable,
	output logic            irq,
	// Serial link
	input  wire link_in_s   link_i,
	output var link_out_s   link_o
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	link_in_s s1_q, s2_q, s3_q;

	// Two flops before use; the third stage only feeds edge detection
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '{sclk: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
			s2_q <= '{sclk: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
			s3_q <= '{sclk: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
		end else begin
			s1_q <= link_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]  ctrl_q, ctrl_d;
	logic [7:0]  stat_q, stat_d; // bits 7..3 used
	logic [7:0]  shift_q, shift_d;
	logic [7:0]  rbuf_q, rbuf_d;
	logic [7:0]  rdata_q, rdata_d;
	logic [7:0]  div_q, div_d;
	logic [3:0]  edge_q, edge_d;
	logic        sclk_q, sclk_d;
	logic        outbit_q, outbit_d;
	logic        inbit_q, inbit_d;
	xfer_state_e st_q, st_d;

	// Decoded controls
	logic en, master_select, clock_idle_level, clock_sample_phase, lsbf;
	logic dism, select_output_enable;
	assign en   = ctrl_q[CTRL_EN];
	assign master_select = ctrl_q[CTRL_MASTER_SELECT];
	assign clock_idle_level = ctrl_q[CTRL_CLOCK_IDLE_LEVEL];
	assign clock_sample_phase = ctrl_q[CTRL_CLOCK_SAMPLE_PHASE];
	assign lsbf = ctrl_q[CTRL_LSBF];
	assign dism = stat_q[STAT_DISM];
	assign select_output_enable = ctrl_q[CTRL_SELECT_OUTPUT_ENABLE];

	// Half-period reload for the master clock divider
	function automatic logic [7:0] half_div(input logic [1:0] sel);
		unique case (sel)
			2'b00: half_div = HALF_DIV0;
			2'b01: half_div = HALF_DIV1;
			2'b10: half_div = HALF_DIV2;
			2'b11: half_div = HALF_DIV3;
		endcase
	endfunction : half_div

	// Bit presented on the data output for the current shifter
	function automatic logic tx_bit(input logic [7:0] v, input logic lf);
		tx_bit = lf ? v[0] : v[7];
	endfunction : tx_bit

	// Shift one bit in at the far end of the shifter
	function automatic logic [7:0] shift_in(input logic [7:0] v,
			input logic lf, input logic b);
		shift_in = lf ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	// ------------------------------------------------------------------
	// Link-side events
	// ------------------------------------------------------------------
	logic ss_low, ss_fall, ss_rise, sclk_edge;
	logic mode_fault, slave_sel, wr_ctrl, wr_stat, wr_data, cfg_change;
	assign ss_low    = !s2_q.ss_n;
	assign ss_fall   = s3_q.ss_n && !s2_q.ss_n;
	assign ss_rise   = !s3_q.ss_n && s2_q.ss_n;
	assign sclk_edge = s3_q.sclk != s2_q.sclk;
	// Mode fault only when master with detection on; slave ignores dism
	assign mode_fault = en && master_select && !dism && ss_low; // [RULE6] [RULE7] [RULE1]
	assign slave_sel  = en && !master_select && ss_low; // [RULE12] [RULE1]
	assign wr_ctrl = wr && (addr == ADDR_CTRL);
	assign wr_stat = wr && (addr == ADDR_STAT);
	assign wr_data = wr && (addr == ADDR_DATA);
	// Format bits changing under an enabled port abort the byte
	assign cfg_change = wr_ctrl && en &&
		(wdata[5:0] != ctrl_q[5:0]); // [RULE18]

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic done_ev, ovf_ev, write_collision_flag_ev, busy, sample, shift_ev;
		logic [7:0] rx;
		done_ev  = 1'b0;
		ovf_ev   = 1'b0;
		write_collision_flag_ev  = 1'b0;
		sample   = 1'b0;
		shift_ev = 1'b0;
		rx       = shift_q;
		busy     = (st_q == ST_RUN);
		ctrl_d   = ctrl_q;
		shift_d  = shift_q;
		rbuf_d   = rbuf_q;
		div_d    = div_q;
		edge_d   = edge_q;
		sclk_d   = sclk_q;
		outbit_d = outbit_q;
		inbit_d  = inbit_q;
		st_d     = st_q;

		// Software access to control
		if (wr_ctrl)
			ctrl_d = wdata;

		// Data write: blocked while done flag set, collides when busy
		if (wr_data && !stat_q[STAT_DONE]) begin // [RULE3]
			if (busy || (slave_sel && !clock_sample_phase)) begin
				write_collision_flag_ev = 1'b1; // [RULE4] [RULE16]
			end else begin
				shift_d  = wdata; // [RULE9]
				outbit_d = tx_bit(wdata, lsbf);
				if (en && master_select) begin // [RULE10]
					st_d   = ST_RUN;
					edge_d = EDGES_PER_BYTE;
					div_d  = half_div(ctrl_q[1:0]); // [RULE24]
				end
			end
		end

		// Byte engine
		unique case (st_q)
			ST_IDLE: begin
				sclk_d = clock_idle_level; // [RULE22]
				// Slave: first bit prepared at select fall, in either phase
				if (slave_sel && (ss_fall || !busy) && st_d == ST_IDLE) begin
					if (ss_fall)
						outbit_d = tx_bit(shift_q, lsbf); // [RULE15]
					st_d   = ST_RUN;
					edge_d = EDGES_PER_BYTE;
				end
			end
			ST_RUN: begin
				if (master_select) begin
					if (div_q == RST_BYTE + 8'h01) begin // [RULE24]
						div_d  = half_div(ctrl_q[1:0]);
						sclk_d = !sclk_q;
						shift_ev = 1'b1;
					end else begin
						div_d = div_q - 8'h01;
					end
				end else begin
					shift_ev = sclk_edge; // [RULE12]
				end
				if (shift_ev) begin
					// Odd edges: first of a bit; phase picks sampling edge
					sample = (edge_q[0] == clock_sample_phase); // [RULE21] [RULE14]
					edge_d = edge_q + 4'h1;
					if (sample) begin
						inbit_d = master_select ? s2_q.miso : s2_q.mosi;
						shift_d = shift_in(shift_q, lsbf,
							master_select ? s2_q.miso : s2_q.mosi);
					end else if (edge_q != EDGES_PER_BYTE || clock_sample_phase) begin
						// Shifting edge; phase 1 shifts on the first edge
						outbit_d = tx_bit(shift_q, lsbf); // [RULE17]
					end
					if (edge_q == LAST_EDGE) begin // [RULE11]
						st_d   = ST_IDLE;
						sclk_d = clock_idle_level;
						done_ev = 1'b1;
						rx = sample ? shift_in(shift_q, lsbf,
							master_select ? s2_q.miso : s2_q.mosi) : shift_q;
					end
				end
				// Slave deselected mid-byte: force the bits shifted in so far to ones
				if (!master_select && ss_rise) begin // [RULE13]
					st_d    = ST_IDLE;
					shift_d = lsbf ? (shift_q | ~(ALL_ONES >> edge_q[3:1]))
						: (shift_q | ~(ALL_ONES << edge_q[3:1]));
				end
			end
			default: st_d = ST_IDLE;
		endcase

		// Move finished byte to the buffer unless it would overrun
		if (done_ev) begin
			if (stat_q[STAT_DONE])
				ovf_ev = 1'b1; // [RULE5] [RULE23]
			else
				rbuf_d = rx; // [RULE11]
		end

		// Mode fault, disable, config change: all force idle
		if (mode_fault) begin // [RULE20]
			ctrl_d[CTRL_MASTER_SELECT] = 1'b0;
			ctrl_d[CTRL_EN]   = 1'b0;
		end
		if (mode_fault || cfg_change || !en) begin // [RULE18]
			st_d     = ST_IDLE;
			sclk_d   = mode_fault ? clock_idle_level : ctrl_d[CTRL_CLOCK_IDLE_LEVEL];
			done_ev  = 1'b0;
		end

		// Status: hardware set wins over software clear
		stat_d = stat_q;
		if (wr_stat)
			stat_d = {stat_q[7:4] & wdata[7:4], wdata[3], 3'b000};
		if (done_ev && !ovf_ev)
			stat_d[STAT_DONE] = 1'b1; // [RULE2]
		if (write_collision_flag_ev)
			stat_d[STAT_WRITE_COLLISION_FLAG] = 1'b1; // [RULE4]
		if (ovf_ev)
			stat_d[STAT_OVF]  = 1'b1; // [RULE5]
		if (mode_fault)
			stat_d[STAT_MODE_FAULT_FLAG] = 1'b1; // [RULE6]

		// Read data valid one cycle after the strobe
		unique case (addr)
			ADDR_CTRL: rdata_d = ctrl_q;
			ADDR_STAT: rdata_d = stat_q;
			ADDR_DATA: rdata_d = rbuf_q; // [RULE9]
			default:   rdata_d = RST_BYTE;
		endcase
		if (!rd)
			rdata_d = RST_BYTE;
	end

	// Registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_q   <= RST_BYTE;
			stat_q   <= RST_BYTE;
			shift_q  <= RST_BYTE;
			rbuf_q   <= RST_BYTE;
			rdata_q  <= RST_BYTE;
			div_q    <= RST_BYTE;
			edge_q   <= EDGES_PER_BYTE;
			sclk_q   <= 1'b0;
			outbit_q <= 1'b0;
			inbit_q  <= 1'b0;
			st_q     <= ST_IDLE;
		end else begin
			ctrl_q   <= ctrl_d;
			stat_q   <= stat_d;
			shift_q  <= shift_d;
			rbuf_q   <= rbuf_d;
			rdata_q  <= rdata_d;
			div_q    <= div_d;
			edge_q   <= edge_d;
			sclk_q   <= sclk_d;
			outbit_q <= outbit_d;
			inbit_q  <= inbit_d;
			st_q     <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rdata = rdata_q;
	// Interrupt from done, overrun or fault; collision does not request
	assign irq = serial_irq_enable && global_irq_enable &&
		(stat_q[STAT_DONE] || stat_q[STAT_OVF] || stat_q[STAT_MODE_FAULT_FLAG]); // [RULE8]

	// Pin drive follows mode; select output only with detect off, select_output_enable on
	always_comb begin
		// Idle level follows the control bit at once, not a cycle late
		link_o.sclk_o  = (st_q == ST_RUN) ? sclk_q : clock_idle_level; // [RULE22]
		link_o.sclk_oe = en && master_select;
		link_o.mosi_o  = outbit_q;
		link_o.mosi_oe = en && master_select;
		link_o.miso_o  = outbit_q;
		link_o.miso_oe = slave_sel; // [RULE12]
		link_o.ss_n_o  = !(st_q == ST_RUN);
		link_o.ss_n_oe = en && master_select && dism && select_output_enable; // [RULE1]
	end

endmodule : spi_port

`default_nettype wire

// ===== verification/spi_port_props.sv
// Checker: port-level properties of the serial port
`timescale 1ns/1ps
`default_nettype none
module spi_port_props
	import spi_port_pkg::*;
(
	// System
	input wire logic       clk_sys,
	input wire logic       nrst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// Interrupt
	input wire logic       serial_irq_enable,
	input wire logic       global_irq_enable,
	input wire logic       irq,
	// Link
	input wire link_in_s   link_i,
	input wire link_out_s  link_o
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic dism_q;
	logic dism_d;
	// Only software moves detect-disable, so a shadow copy is exact
	always_comb begin
		dism_d = dism_q;
		if (wr && addr == ADDR_STAT)
			dism_d = wdata[STAT_DISM];
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			dism_q <= 1'b0;
		else
			dism_q <= dism_d;
	end
	// ----
	// Steps
	// ----
	sequence ctrl_on;
		wr && addr == ADDR_CTRL && wdata[CTRL_EN] && wdata[CTRL_MASTER_SELECT];
	endsequence
	sequence fault_seen;
		!dism_q && link_o.sclk_oe && !link_i.ss_n;
	endsequence
	rdata_idle_a: assert property (
		!rd |=> rdata == RST_BYTE) else $error("stray read data");
	irq_gate_a: assert property (
		!(serial_irq_enable && global_irq_enable) |-> !irq)
		else $error("irq while disabled");
	idle_level_a: assert property (
		ctrl_on |-> ##2 link_o.sclk_o == $past(wdata[CTRL_CLOCK_IDLE_LEVEL], 2))
		else $error("clock idle level wrong");
	slave_quiet_a: assert property (
		wr && addr == ADDR_CTRL && !wdata[CTRL_MASTER_SELECT]
		|-> ##2 !link_o.sclk_oe && !link_o.mosi_oe)
		else $error("slave drives clock");
	fault_stop_a: assert property (
		fault_seen |-> ##[1:5] !link_o.sclk_oe)
		else $error("mode fault left port on");
	select_role_a: assert property (
		!(dism_q && link_o.sclk_oe) |-> !link_o.ss_n_oe)
		else $error("select driven wrongly");
	frame_clock_a: assert property (
		link_o.ss_n_oe && $past(link_o.ss_n_oe) && link_o.ss_n_o
		&& $past(link_o.ss_n_o) |-> $stable(link_o.sclk_o))
		else $error("clock moves outside frame");
	no_miso_a: assert property (
		link_o.sclk_oe |-> !link_o.miso_oe)
		else $error("master drives miso");
endmodule : spi_port_props
bind spi_port spi_port_props props (.clk_sys, .nrst, .addr, .wdata,
	.wr, .rd, .rdata, .serial_irq_enable, .global_irq_enable, .irq,
	.link_i, .link_o);
`default_nettype wire

// ===== verification/spi_far_end.sv
// Partner: far serial device, slave when the port is master and back
`timescale 1ns/1ps
`default_nettype none
module spi_far_end
	import spi_port_pkg::*;
(
	// Link
	input wire link_out_s lo,
	output wire link_in_s li,
	// Shared clock format
	input wire logic      clock_idle_level,
	input wire logic      clock_sample_phase
);
	logic       sck, mo, ss, so, act;
	logic [7:0] sh, rx;
	initial begin
		{sck, mo, ss, so, sh, rx} = {4'b0010, 16'h0000};
		act = 1'b0;
	end
	// Frame flag lags select by a delta so the last edge still counts
	always @(li.ss_n) act <= !li.ss_n;
	// Each pin follows whichever side enables its driver
	assign li.sclk = lo.sclk_oe ? lo.sclk_o : sck;
	assign li.mosi = lo.mosi_oe ? lo.mosi_o : mo;
	assign li.miso = lo.miso_oe ? lo.miso_o : so;
	assign li.ss_n = lo.ss_n_oe ? lo.ss_n_o : ss;
	// Released miso flips so a stale level is never mistaken for data
	always @(posedge li.ss_n) so = ~so;
	always @(negedge li.ss_n) if (lo.sclk_oe && !clock_sample_phase) so = sh[7];
	// Slave role, same format as the port
	always @(lo.sclk_o) if (lo.sclk_oe && act) begin
		if ((lo.sclk_o != clock_idle_level) ^ clock_sample_phase)
			rx = {rx[6:0], li.mosi};
		else if (clock_sample_phase) begin
			so = sh[7];
			sh = sh << 1;
		end else begin
			sh = sh << 1;
			so = sh[7];
		end
	end
	// Master role, phase 1, half period 80 ns, off the system grid
	task automatic send(input logic [7:0] b);
		int i;
		#3;
		ss = 1'b0;
		#80;
		for (i = 7; i >= 0; i--) begin
			sck = ~sck;
			mo = b[i];
			#80;
			sck = ~sck;
			rx = {rx[6:0], li.miso};
			#80;
		end
		ss = 1'b1;
		mo = ~mo;
		#80;
	endtask : send
endmodule : spi_far_end
`default_nettype wire

// ===== verification/spi_port_tb.sv
// Testbench: register-level tests of the serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module spi_port_tb
	import spi_port_pkg::*;
;
	logic       clk_sys, nrst, wr, rd, irq, clock_idle_level, clock_sample_phase;
	logic       serial_irq_enable, global_irq_enable;
	logic [7:0] addr, wdata, rdata, v;
	link_in_s   link_i;
	link_out_s  link_o;
	int         num_errors, n_tests;
	spi_port dut (.clk_sys, .nrst, .addr, .wdata, .wr, .rd, .rdata,
		.serial_irq_enable, .global_irq_enable, .irq, .link_i, .link_o);
	spi_far_end far (.lo(link_o), .li(link_i), .clock_idle_level, .clock_sample_phase);
	always #5 clk_sys = ~clk_sys;
	// Every access leaves one idle edge so strobes never merge
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wreg
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clk_sys);
		`CHK(v, e)
	endtask : rchk
	task automatic wait_done;
		int i;
		v = 8'h00;
		for (i = 0; i < 400 && v[STAT_DONE] !== 1'b1; i++) begin
			addr <= ADDR_STAT;
			rd <= 1'b1;
			@(posedge clk_sys);
			rd <= 1'b0;
			#1 v = rdata;
			@(posedge clk_sys);
		end
	endtask : wait_done
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// Watchdog well beyond the longest expected run
	initial begin
		#500000;
		num_errors++;
		end_of_test;
	end
	initial begin
		{clk_sys, nrst, wr, rd, clock_idle_level, clock_sample_phase} = 6'h00;
		{addr, wdata} = 16'h0000;
		{serial_irq_enable, global_irq_enable} = 2'b11;
		{num_errors, n_tests} = 0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		rchk(ADDR_STAT, RST_BYTE);
		rchk(ADDR_DATA, RST_BYTE);
		rchk(8'hF0, RST_BYTE);
		$display("reset test done");
		// All four formats, one rate each; second write collides
		for (int m = 0; m < 4; m++) begin
			wreg(ADDR_CTRL, 8'h00);
			wreg(ADDR_STAT, 8'h08);
			{clock_idle_level, clock_sample_phase} <= m[1:0];
			wreg(ADDR_CTRL, {4'hD, m[1:0], m[1:0]});
			far.sh = 8'h3C ^ m[7:0];
			wreg(ADDR_DATA, 8'hA5 ^ m[7:0]);
			wreg(ADDR_DATA, 8'hFF);
			wait_done;
			rchk(ADDR_STAT, 8'hC8);
			rchk(ADDR_DATA, 8'h3C ^ m[7:0]);
			`CHK(far.rx, 8'hA5 ^ m[7:0])
			`CHK(irq, 1'b1)
			wreg(ADDR_DATA, 8'h00);
			repeat (40) @(posedge clk_sys);
			`CHK(far.rx, 8'hA5 ^ m[7:0])
		end
		$display("master test done");
		// Foreign select low while master with detection on
		wreg(ADDR_CTRL, 8'h00);
		wreg(ADDR_STAT, 8'h00);
		{clock_idle_level, clock_sample_phase} <= 2'b00;
		wreg(ADDR_CTRL, 8'h50);
		global_irq_enable <= 1'b0;
		far.ss <= 1'b0;
		repeat (6) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		rchk(ADDR_STAT, 8'h10);
		rchk(ADDR_CTRL, 8'h00);
		global_irq_enable <= 1'b1;
		far.ss <= 1'b1;
		@(posedge clk_sys);
		#1 `CHK(irq, 1'b1)
		$display("fault test done");
		// Slave, phase 1; second byte lands before the flag is cleared
		wreg(ADDR_STAT, 8'h00);
		{clock_idle_level, clock_sample_phase} <= 2'b01;
		wreg(ADDR_CTRL, 8'h44);
		wreg(ADDR_DATA, 8'h5A);
		far.send(8'hC3);
		`CHK(far.rx, 8'h5A)
		far.send(8'h99);
		@(posedge clk_sys);
		rchk(ADDR_STAT, 8'hA0);
		rchk(ADDR_DATA, 8'hC3);
		$display("slave test done");
		end_of_test;
	end
endmodule : spi_port_tb
`default_nettype wire
